// ==== logic/srwp_pkg.sv ====
// shared constants and types for the sram write port with lane masks
package srwp_pkg;

    // pin-level widths for the widest organisation
    localparam int MAX_DATA_WIDTH = 36;
    localparam int MAX_ADDR_WIDTH = 22;
    localparam int NIBBLE_SELECTS = 2;
    localparam int BYTE_SELECTS = 4;

    // lane geometry
    localparam int NIBBLE_ORG_WIDTH = 8;
    localparam int NIBBLE_LANE_BITS = 4;
    localparam int BYTE_LANE_BITS = 9;

    // burst: two words per loaded address, one per input clock edge
    localparam int BURST_WORDS = 2;
    localparam int BEAT_RISE = 0;
    localparam int BEAT_FALL = 1;

    // system clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int SYNC_STAGES = 2;

    // direction pin encoding while the load strobe is low, plus active strobe and select levels
    localparam logic DIR_READ = 1'h1;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic STROBE_ACTIVE = 1'h0;
    localparam logic SELECT_ACTIVE = 1'h0;

    // write-burst sequencer
    typedef enum logic [2:0] {
        SRWP_IDLE = 3'h1,
        SRWP_SECOND = 3'h2,
        SRWP_COMMIT = 3'h4
    } srwp_state_type;

    // pin group as seen after synchronisation
    typedef struct packed {
        logic loadStrobeN;
        logic readNotWrite;
        logic [MAX_ADDR_WIDTH-1:0] addr;
        logic [MAX_DATA_WIDTH-1:0] data;
        logic [NIBBLE_SELECTS-1:0] nibbleSelN;
        logic [BYTE_SELECTS-1:0] byteSelN;
    } srwp_pins_type;

endpackage : srwp_pkg

// ==== logic/srwp_write_port.sv ====
// write port of a two-word burst ddr separate-io sram with nibble and byte masks
//
// Functional notes
// - write data captured on main clock rise and complement clock rise during writes.
// - data input width is 8, 9, 18 or 36 bits by organisation.
// - each transaction moves exactly two words, one per clock edge.
// - 8-bit part samples two active-low nibble selects on both edges during writes.
// - nibble with inactive select keeps its stored contents.
// - nibble select 0 gates bits 3..0, select 1 gates bits 7..4.
// - nibble selects sampled on the same edge as their data beat.
// - deasserted nibble select means that nibble of data is ignored.
// - 9/18/36-bit parts sample active-low byte selects on both edges during writes.
// - byte lane with inactive select keeps its stored contents.
// - byte selects 0..3 gate bits 8..0, 17..9, 26..18, 35..27.
// - byte selects sampled on the same edge as their data beat.
// - deasserted byte select means that byte of data is ignored.
// - with load strobe low, direction high means read, low means write.
// - address sampled and accesses started on main clock rising edge.
`timescale 1ns/1ps

module srwp_write_port #(
    parameter int DATA_WIDTH = 36,
    parameter int ADDR_WIDTH = 20
) (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // input clocks from the controller, sampled as plain pins
    input wire logic kClk,
    input wire logic kClkBar,
    // command pins
    input wire logic load_strobe_n,
    input wire logic readNotWrite,
    input wire logic [ADDR_WIDTH-1:0] addr,
    // data and lane masks
    input wire logic [DATA_WIDTH-1:0] writeData,
    input wire logic [srwp_pkg::NIBBLE_SELECTS-1:0] nibble_write_select_n,
    input wire logic [srwp_pkg::BYTE_SELECTS-1:0] byte_write_select_n,
    // array observation, same clock domain
    input wire logic [ADDR_WIDTH-1:0] peekAddr,
    input wire logic peekBeat,
    output logic [DATA_WIDTH-1:0] peekData,
    // burst completion
    output logic writeDone,
    output logic [ADDR_WIDTH-1:0] writeDoneAddr
);

    localparam int DEPTH = 2 ** (ADDR_WIDTH + 1);
    localparam bit NIBBLE_ORG = (DATA_WIDTH == srwp_pkg::NIBBLE_ORG_WIDTH);

    // pin synchronisers: every pin shares the same depth so beats stay aligned
    srwp_pkg::srwp_pins_type pinsRaw;
    srwp_pkg::srwp_pins_type pinsMeta;
    srwp_pkg::srwp_pins_type pins;
    logic kMeta;
    logic kSync;
    logic kPrev;
    logic kbMeta;
    logic kbSync;
    logic kbPrev;
    logic kRise;
    logic kbRise;

    always_comb begin
        pinsRaw = '0;
        pinsRaw.loadStrobeN = load_strobe_n;
        pinsRaw.readNotWrite = readNotWrite;
        pinsRaw.addr[ADDR_WIDTH-1:0] = addr;
        pinsRaw.data[DATA_WIDTH-1:0] = writeData;
        pinsRaw.nibbleSelN = nibble_write_select_n;
        pinsRaw.byteSelN = byte_write_select_n;
    end

    // idle pins read as strobe high, selects inactive, clocks low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pinsMeta <= '1;
            pins <= '1;
            kMeta <= 1'h0;
            kSync <= 1'h0;
            kPrev <= 1'h0;
            kbMeta <= 1'h0;
            kbSync <= 1'h0;
            kbPrev <= 1'h0;
        end else begin
            pinsMeta <= pinsRaw;
            pins <= pinsMeta;
            kMeta <= kClk;
            kSync <= kMeta;
            kPrev <= kSync;
            kbMeta <= kClkBar;
            kbSync <= kbMeta;
            kbPrev <= kbSync;
        end
    end

    assign kRise = kSync & ~kPrev;
    assign kbRise = kbSync & ~kbPrev;

    // lane mask: a bit is written only when its lane select is active
    logic [DATA_WIDTH-1:0] bitEnable;
    genvar gb;
    generate
        for (gb = 0; gb < DATA_WIDTH; gb++) begin : g_lane
            if (NIBBLE_ORG) begin : g_nib
                assign bitEnable[gb] = (pins.nibbleSelN[gb / srwp_pkg::NIBBLE_LANE_BITS]
                    == srwp_pkg::SELECT_ACTIVE);
            end else begin : g_byte
                assign bitEnable[gb] = (pins.byteSelN[gb / srwp_pkg::BYTE_LANE_BITS]
                    == srwp_pkg::SELECT_ACTIVE);
            end
        end
    endgenerate

    // sequencer
    srwp_pkg::srwp_state_type state;
    srwp_pkg::srwp_state_type next_state;
    logic [ADDR_WIDTH-1:0] burstAddr;
    logic [ADDR_WIDTH-1:0] next_burstAddr;
    logic next_writeDone;
    logic [ADDR_WIDTH-1:0] next_writeDoneAddr;
    logic arrayWrite;
    logic arrayBeat;
    logic [ADDR_WIDTH-1:0] arrayAddr;
    logic newWrite;

    // load strobe low with direction low opens a write burst
    assign newWrite = kRise && pins.loadStrobeN == srwp_pkg::STROBE_ACTIVE
        && pins.readNotWrite == srwp_pkg::DIR_WRITE;

    always_comb begin
        next_state = state;
        next_burstAddr = burstAddr;
        next_writeDone = 1'h0;
        next_writeDoneAddr = writeDoneAddr;
        arrayWrite = 1'h0;
        arrayBeat = 1'(srwp_pkg::BEAT_RISE);
        arrayAddr = burstAddr;
        case (state)
            srwp_pkg::SRWP_IDLE, srwp_pkg::SRWP_COMMIT: begin
                next_state = srwp_pkg::SRWP_IDLE;
                if (newWrite) begin
                    // first beat rides the same edge as the address
                    arrayWrite = 1'h1;
                    arrayAddr = pins.addr[ADDR_WIDTH-1:0];
                    next_burstAddr = pins.addr[ADDR_WIDTH-1:0];
                    next_state = srwp_pkg::SRWP_SECOND;
                end
            end
            srwp_pkg::SRWP_SECOND: begin
                if (kbRise) begin
                    // second beat uses masks sampled with it, not the first ones
                    arrayWrite = 1'h1;
                    arrayBeat = 1'(srwp_pkg::BEAT_FALL);
                    next_writeDone = 1'h1;
                    next_writeDoneAddr = burstAddr;
                    next_state = srwp_pkg::SRWP_COMMIT;
                end
            end
            default: begin
                next_state = srwp_pkg::SRWP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= srwp_pkg::SRWP_IDLE;
            burstAddr <= '0;
            writeDone <= 1'h0;
            writeDoneAddr <= '0;
        end else begin
            state <= next_state;
            burstAddr <= next_burstAddr;
            writeDone <= next_writeDone;
            writeDoneAddr <= next_writeDoneAddr;
        end
    end

    // array: two words per address, masked merge keeps unselected lanes
    logic [DATA_WIDTH-1:0] mem [0:DEPTH-1];
    logic [ADDR_WIDTH:0] memIndex;
    logic [DATA_WIDTH-1:0] oldWord;
    logic [DATA_WIDTH-1:0] mergedWord;
    logic [DATA_WIDTH-1:0] next_peekData;

    assign memIndex = {arrayAddr, arrayBeat};
    assign oldWord = mem[memIndex];
    assign mergedWord = (oldWord & ~bitEnable)
        | (pins.data[DATA_WIDTH-1:0] & bitEnable);
    assign next_peekData = mem[{peekAddr, peekBeat}];

    // no reset on the array: contents are undefined until written
    always_ff @(posedge clk) begin
        if (arrayWrite) begin
            mem[memIndex] <= mergedWord;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            peekData <= '0;
        end else begin
            peekData <= next_peekData;
        end
    end

    // checks
    logic [DATA_WIDTH-1:0] chkOld;
    logic [DATA_WIDTH-1:0] chkEn;
    logic [DATA_WIDTH-1:0] chkData;
    logic [ADDR_WIDTH:0] chkIndex;
    logic chkWrote;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chkWrote <= 1'h0;
            chkOld <= '0;
            chkEn <= '0;
            chkData <= '0;
            chkIndex <= '0;
        end else begin
            chkWrote <= arrayWrite;
            chkOld <= oldWord;
            chkEn <= bitEnable;
            chkData <= pins.data[DATA_WIDTH-1:0];
            chkIndex <= memIndex;
        end
    end

    a_masked_keep: assert property (@(posedge clk) disable iff (sys_rst)
        chkWrote |-> ((mem[chkIndex] & ~chkEn) == (chkOld & ~chkEn)))
        else $error("unselected lane changed");

    a_selected_write: assert property (@(posedge clk) disable iff (sys_rst)
        chkWrote |-> ((mem[chkIndex] & chkEn) == (chkData & chkEn)))
        else $error("selected lane not written");

    a_read_ignored: assert property (@(posedge clk) disable iff (sys_rst)
        (state != srwp_pkg::SRWP_SECOND && kRise && pins.readNotWrite == srwp_pkg::DIR_READ)
        |=> state == srwp_pkg::SRWP_IDLE)
        else $error("read started a write burst");

    a_addr_on_rise: assert property (@(posedge clk) disable iff (sys_rst)
        (state != srwp_pkg::SRWP_SECOND && newWrite)
        |=> (burstAddr == $past(pins.addr[ADDR_WIDTH-1:0]) && state == srwp_pkg::SRWP_SECOND))
        else $error("address not taken on main rise");

    a_second_beat: assert property (@(posedge clk) disable iff (sys_rst)
        (state == srwp_pkg::SRWP_SECOND && kbRise)
        |=> (writeDone && writeDoneAddr == $past(burstAddr)))
        else $error("second beat did not close burst");

    a_done_cause: assert property (@(posedge clk) disable iff (sys_rst)
        writeDone |-> ($past(state) == srwp_pkg::SRWP_SECOND && $past(kbRise)))
        else $error("done without second beat");

    a_done_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        writeDone |=> !writeDone)
        else $error("done longer than one cycle");

    a_beat_select: assert property (@(posedge clk) disable iff (sys_rst)
        arrayWrite |-> (arrayBeat == (state == srwp_pkg::SRWP_SECOND)))
        else $error("beat written to wrong word");

    a_wait_second: assert property (@(posedge clk) disable iff (sys_rst)
        (state == srwp_pkg::SRWP_SECOND && !kbRise) |-> !arrayWrite)
        else $error("write without its own edge");

    a_idle_no_write: assert property (@(posedge clk) disable iff (sys_rst)
        (state != srwp_pkg::SRWP_SECOND && !newWrite) |-> !arrayWrite)
        else $error("array written without a loaded write");

    a_strobe_high: assert property (@(posedge clk) disable iff (sys_rst)
        (state != srwp_pkg::SRWP_SECOND && kRise
        && pins.loadStrobeN != srwp_pkg::STROBE_ACTIVE) |=> state == srwp_pkg::SRWP_IDLE)
        else $error("burst opened without load strobe");

    a_first_beat: assert property (@(posedge clk) disable iff (sys_rst)
        (state != srwp_pkg::SRWP_SECOND && newWrite)
        |-> (arrayWrite && arrayBeat == 1'(srwp_pkg::BEAT_RISE)
        && arrayAddr == pins.addr[ADDR_WIDTH-1:0]))
        else $error("first beat not written at loaded address");

    a_second_write: assert property (@(posedge clk) disable iff (sys_rst)
        (state == srwp_pkg::SRWP_SECOND && kbRise) |-> (arrayWrite && arrayAddr == burstAddr))
        else $error("second beat not written at burst address");

    a_hold_second: assert property (@(posedge clk) disable iff (sys_rst)
        (state == srwp_pkg::SRWP_SECOND && !kbRise)
        |=> (state == srwp_pkg::SRWP_SECOND && burstAddr == $past(burstAddr)))
        else $error("burst left before its second beat");

    a_done_addr_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (writeDoneAddr != $past(writeDoneAddr)) |-> writeDone)
        else $error("done address moved without a burst");

    a_state_onehot: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot(state))
        else $error("sequencer state not one-hot");

endmodule : srwp_write_port

// ==== dv/srwp_ctrl_model.sv ====
// memory controller model driving clocks, command, data and lane masks
`timescale 1ns/1ps

module srwp_ctrl_model (
    // system
    input wire logic clk,
    // pins toward the write port
    output logic kClk,
    output logic kClkBar,
    output logic loadN,
    output logic rnw,
    output logic [3:0] addr,
    output logic [35:0] data,
    output logic [3:0] byteSelN,
    output logic [1:0] nibSelN
);
    initial begin
        kClk = 1'h0;
        kClkBar = 1'h0;
        loadN = 1'h1;
        rnw = 1'h1;
        addr = 4'h0;
        data = 36'h0;
        byteSelN = 4'hF;
        nibSelN = 2'h3;
    end

    // one two-word burst; slow stretches the high phase of each clock to mimic a stalling controller
    task automatic burst(input logic [3:0] a, input logic [35:0] d0, input logic [3:0] m0,
                         input logic [35:0] d1, input logic [3:0] m1, input logic ld,
                         input logic rd, input int slow);
        @(negedge clk);
        kClk = 1'h1;
        loadN = ld;
        rnw = rd;
        addr = a;
        data = d0;
        byteSelN = m0;
        nibSelN = m0[1:0];
        repeat (4 + slow) @(negedge clk);
        kClk = 1'h0;
        loadN = 1'h1;
        addr = ~a;
        data = d1;
        byteSelN = m1;
        nibSelN = m1[1:0];
        repeat (2) @(negedge clk);
        kClkBar = 1'h1;
        repeat (4 + slow) @(negedge clk);
        kClkBar = 1'h0;
        // released bus shows the inverse, not a stale copy
        rnw = ~rd;
        data = ~d1;
        byteSelN = ~m1;
        nibSelN = ~m1[1:0];
        repeat (2) @(negedge clk);
    endtask : burst
endmodule : srwp_ctrl_model

// ==== dv/sram_write_port_byte_masks_tb.sv ====
// testbench for the sram write port with byte-lane masks
`timescale 1ns/1ps

module sram_write_port_byte_masks_tb;
    logic clk, sys_rst, kClk, kClkBar, loadN, rnw, peekBeat, writeDone;
    logic [3:0] addr, peekAddr, writeDoneAddr, byteSelN;
    logic [1:0] nibSelN;
    logic [35:0] data, peekData;
    logic [35:0] expMem [0:31];
    logic writeDoneNib;
    logic [3:0] writeDoneAddrNib;
    logic [7:0] peekDataNib;
    logic [7:0] expMemNib [0:31];
    int failures = 0;
    int n_compared = 0;
    int doneCnt = 0;
    int doneCntNib = 0;

    srwp_ctrl_model ctl (.clk(clk), .kClk(kClk), .kClkBar(kClkBar), .loadN(loadN), .rnw(rnw),
        .addr(addr), .data(data), .byteSelN(byteSelN), .nibSelN(nibSelN));

    srwp_write_port #(.DATA_WIDTH(36), .ADDR_WIDTH(4)) dut (.clk(clk), .sys_rst(sys_rst),
        .kClk(kClk), .kClkBar(kClkBar), .load_strobe_n(loadN), .readNotWrite(rnw),
        .addr(addr), .writeData(data), .nibble_write_select_n(nibSelN),
        .byte_write_select_n(byteSelN), .peekAddr(peekAddr), .peekBeat(peekBeat),
        .peekData(peekData), .writeDone(writeDone), .writeDoneAddr(writeDoneAddr));

    // nibble organisation shares the same pins, low data byte only
    srwp_write_port #(.DATA_WIDTH(8), .ADDR_WIDTH(4)) dutNib (.clk(clk), .sys_rst(sys_rst),
        .kClk(kClk), .kClkBar(kClkBar), .load_strobe_n(loadN), .readNotWrite(rnw),
        .addr(addr), .writeData(data[7:0]), .nibble_write_select_n(nibSelN),
        .byte_write_select_n(byteSelN), .peekAddr(peekAddr), .peekBeat(peekBeat),
        .peekData(peekDataNib), .writeDone(writeDoneNib), .writeDoneAddr(writeDoneAddrNib));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (writeDone === 1'h1) begin
            doneCnt <= doneCnt + 1;
        end
        if (writeDoneNib === 1'h1) begin
            doneCntNib <= doneCntNib + 1;
        end
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                          input logic [3:0] m);
        for (int i = 0; i < 4; i++) begin
            if (m[i] === 1'h0) begin
                o[9*i +: 9] = n[9*i +: 9];
            end
        end
        return o;
    endfunction : merge

    function automatic logic [7:0] mergeNib(input logic [7:0] o, input logic [7:0] n,
                                            input logic [1:0] m);
        for (int i = 0; i < 2; i++) begin
            if (m[i] === 1'h0) begin
                o[4*i +: 4] = n[4*i +: 4];
            end
        end
        return o;
    endfunction : mergeNib

    task automatic peek(input logic [3:0] a, input logic b);
        @(negedge clk);
        peekAddr = a;
        peekBeat = b;
        @(negedge clk);
        chk(peekData, expMem[{a, b}]);
        chk(36'(peekDataNib), 36'(expMemNib[{a, b}]));
    endtask : peek

    // burst, then judge done pulse, done address and both stored words
    task automatic wr(input logic [3:0] a, input logic [35:0] d0, input logic [3:0] m0,
                      input logic [35:0] d1, input logic [3:0] m1, input logic ld,
                      input logic rd, input int slow);
        int c0;
        int cNib;
        logic w;
        c0 = doneCnt;
        cNib = doneCntNib;
        w = !ld && !rd;
        ctl.burst(a, d0, m0, d1, m1, ld, rd, slow);
        if (w) begin
            expMem[{a, 1'h0}] = merge(expMem[{a, 1'h0}], d0, m0);
            expMem[{a, 1'h1}] = merge(expMem[{a, 1'h1}], d1, m1);
            chk(36'(writeDoneAddr), 36'(a));
            expMemNib[{a, 1'h0}] = mergeNib(expMemNib[{a, 1'h0}], d0[7:0], m0[1:0]);
            expMemNib[{a, 1'h1}] = mergeNib(expMemNib[{a, 1'h1}], d1[7:0], m1[1:0]);
            chk(36'(writeDoneAddrNib), 36'(a));
        end
        chk(36'(doneCnt - c0), 36'(w));
        chk(36'(doneCntNib - cNib), 36'(w));
        peek(a, 1'h0);
        peek(a, 1'h1);
    endtask : wr

    task automatic t_full();
        wr(4'h3, 36'h123456789, 4'h0, 36'hFEDCBA987, 4'h0, 1'h0, 1'h0, 0);
    endtask : t_full

    task automatic t_b2b();
        wr(4'h5, 36'h0F0F0F0F0, 4'h0, 36'h111111111, 4'h0, 1'h0, 1'h0, 0);
        wr(4'h6, 36'h222222222, 4'h0, 36'h333333333, 4'h0, 1'h0, 1'h0, 0);
    endtask : t_b2b

    // each lane masked alone on beat one and written alone on beat two
    task automatic t_lanes();
        for (int i = 0; i < 4; i++) begin
            wr(4'h3, 36'hA5A5A5A5A ^ 36'(i), 4'h1 << i, 36'h5A5A5A5A5 + 36'(i),
               ~(4'h1 << i), 1'h0, 1'h0, i);
        end
    endtask : t_lanes

    task automatic t_refused();
        wr(4'h5, 36'hDEADBEEF0, 4'h0, 36'hCAFEF00D1, 4'h0, 1'h0, 1'h1, 0);
        wr(4'h6, 36'h777777777, 4'h0, 36'h888888888, 4'h0, 1'h1, 1'h0, 0);
    endtask : t_refused

    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    initial begin
        sys_rst = 1'h1;
        peekAddr = 4'h0;
        peekBeat = 1'h0;
        repeat (6) @(negedge clk);
        sys_rst = 1'h0;
        t_full();
        t_b2b();
        t_lanes();
        t_refused();
        results();
    end

    // all bursts take well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        results();
    end
endmodule : sram_write_port_byte_masks_tb
